// [bre_consts.vh]
// constants for the boundary-run test engine
`ifndef BRE_CONSTS_VH
`define BRE_CONSTS_VH

// ----------------------------------------------------------------
// instruction register
// ----------------------------------------------------------------
`define BRE_IR_W            8
`define BRE_IR_CAPTURE      8'h81
`define BRE_IR_RESET        8'hFF
`define BRE_OP_RUN          8'h09
`define BRE_OP_CTRL_NORMAL  8'h8E
`define BRE_OP_CTRL_TEST    8'h0F
`define BRE_OP_READ_NORMAL  8'h0A
`define BRE_OP_READ_TEST    8'h8B

// ----------------------------------------------------------------
// test-operation control register
// ----------------------------------------------------------------
`define BRE_CTRL_W          3
`define BRE_CTRL_RESET      3'h0
`define BRE_CODE_TOGGLE     2'h0
`define BRE_CODE_PATTERN36  2'h1
`define BRE_CODE_SIGN36     2'h2
`define BRE_CODE_COMBINED   2'h3

// ----------------------------------------------------------------
// boundary cell chain layout
// ----------------------------------------------------------------
`define BRE_CHAIN_W         48
`define BRE_CHAIN_RESET     48'h000000000000
`define BRE_CELL_AB_EN1     47
`define BRE_CELL_AB_EN2     46
`define BRE_CELL_BA_EN1     45
`define BRE_CELL_BA_EN2     44
`define BRE_B_LSB           18
`define BRE_A_LSB           0

// ----------------------------------------------------------------
// feedback taps, maximal length
// ----------------------------------------------------------------
`define BRE_TAP36_HI        35
`define BRE_TAP36_LO        24
`define BRE_TAP18_HI        17
`define BRE_TAP18_LO        10

`endif

// [bre_boundary_run_engine.v]
// boundary-run test engine with its tap controller and scan registers
// Summary of operation
// R1 - control-register scan puts control register in path; capture leaves it unchanged
// R2 - controller loads operation code before issuing the boundary-run instruction
// R3 - operation decoded from control bits 2..0, runs only in run-test/idle
// R4 - code x00 selects sample inputs and toggle outputs
// R5 - x01 selects 36-bit pattern generation, x10 selects 36-bit signature
// R6 - 011 gives 18-bit signature plus pattern, 111 signature plus count
// R7 - cells 47..36 excluded from algorithms; 47..44 still set output drive
// R8 - operations need opposite enables per byte, same direction; else bypass
// R9 - toggle mode: input-mode cells capture their pins each rising edge
// R10 - toggle mode: output cells invert on rise, drive pins on fall
// R11 - 36-bit mode: cells step as LFSR on rise, pins update on fall
// R12 - controller scans a seed into the chain before pattern or signature
// R13 - an all-zero pattern seed stays zero in both widths
// R14 - 36-bit signature folds input pins into the chain each rising edge
// R15 - during 36-bit signature output shadow latches hold and keep driving
// R16 - combined mode: 18-bit signature on inputs, 18-bit pattern on outputs
// R17 - combined count mode: 18-bit signature on inputs, outputs count up
// R18 - cell arrangement differs between a-to-b and b-to-a directions
// R19 - taps x^36+x^25+1 and x^18+x^11+1, both maximal length
// R20 - 18-bit counter adds one per rising edge and wraps to zero
// R21 - run instruction 00001001 selects bypass, test mode, runs operation
// R22 - an enable cell at zero makes its pins outputs, one makes inputs
`timescale 1ns/1ps
`default_nettype none
`include "bre_consts.vh"

module bre_boundary_run_engine #(
  parameter PORT_W = 18
) (
  input  wire              clk,
  input  wire              reset_n,
  input  wire              tck,
  input  wire              tms,
  input  wire              tdi,
  output reg               tdo,
  output reg               tdoOe,
  input  wire [PORT_W-1:0] aPinIn,
  output reg  [PORT_W-1:0] aPinOut,
  output reg  [PORT_W-1:0] aPinOe,
  input  wire [PORT_W-1:0] bPinIn,
  output reg  [PORT_W-1:0] bPinOut,
  output reg  [PORT_W-1:0] bPinOe,
  output reg               testMode
);

  // ----------------------------------------------------------------
  // tap states
  // ----------------------------------------------------------------
  localparam [3:0] ST_RESET = 4'h0, ST_IDLE = 4'h1, ST_SEL_DR = 4'h2, ST_CAP_DR = 4'h3;
  localparam [3:0] ST_SH_DR = 4'h4, ST_EX1_DR = 4'h5, ST_PA_DR = 4'h6, ST_EX2_DR = 4'h7;
  localparam [3:0] ST_UPD_DR = 4'h8, ST_SEL_IR = 4'h9, ST_CAP_IR = 4'hA, ST_SH_IR = 4'hB;
  localparam [3:0] ST_EX1_IR = 4'hC, ST_PA_IR = 4'hD, ST_EX2_IR = 4'hE, ST_UPD_IR = 4'hF;
  localparam HALF = PORT_W / 2;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // standard tap transition
  function [3:0] tapNext;
    input [3:0] s;
    input       m;
    begin
      case (s)
        ST_RESET:  tapNext = m ? ST_RESET  : ST_IDLE;
        ST_IDLE:   tapNext = m ? ST_SEL_DR : ST_IDLE;
        ST_SEL_DR: tapNext = m ? ST_SEL_IR : ST_CAP_DR;
        ST_CAP_DR: tapNext = m ? ST_EX1_DR : ST_SH_DR;
        ST_SH_DR:  tapNext = m ? ST_EX1_DR : ST_SH_DR;
        ST_EX1_DR: tapNext = m ? ST_UPD_DR : ST_PA_DR;
        ST_PA_DR:  tapNext = m ? ST_EX2_DR : ST_PA_DR;
        ST_EX2_DR: tapNext = m ? ST_UPD_DR : ST_SH_DR;
        ST_UPD_DR: tapNext = m ? ST_SEL_DR : ST_IDLE;
        ST_SEL_IR: tapNext = m ? ST_RESET  : ST_CAP_IR;
        ST_CAP_IR: tapNext = m ? ST_EX1_IR : ST_SH_IR;
        ST_SH_IR:  tapNext = m ? ST_EX1_IR : ST_SH_IR;
        ST_EX1_IR: tapNext = m ? ST_UPD_IR : ST_PA_IR;
        ST_PA_IR:  tapNext = m ? ST_EX2_IR : ST_PA_IR;
        ST_EX2_IR: tapNext = m ? ST_UPD_IR : ST_SH_IR;
        ST_UPD_IR: tapNext = m ? ST_SEL_DR : ST_IDLE;
        default:   tapNext = ST_RESET;
      endcase
    end
  endfunction

  // R19 36-bit step
  // R13 zero seed fixed
  function [35:0] step36;
    input [35:0] r;
    begin
      step36 = {r[34:0], r[`BRE_TAP36_HI] ^ r[`BRE_TAP36_LO]};
    end
  endfunction

  // R19 18-bit step
  function [17:0] step18;
    input [17:0] r;
    begin
      step18 = {r[16:0], r[`BRE_TAP18_HI] ^ r[`BRE_TAP18_LO]};
    end
  endfunction

  // ----------------------------------------------------------------
  // synchronisers and tck edges
  // ----------------------------------------------------------------
  reg [2:0]        tckSyncQ;
  reg [1:0]        tmsSyncQ;
  reg [1:0]        tdiSyncQ;
  reg [PORT_W-1:0] aSync1Q, aSync2Q, bSync1Q, bSync2Q;
  wire             tckRise = tckSyncQ[1] & ~tckSyncQ[2];
  wire             tckFall = ~tckSyncQ[1] & tckSyncQ[2];

  // two flops per pin, third tck flop only for edge finding
  always @(posedge clk) begin
    if (!reset_n) begin
      tckSyncQ <= 3'h7;  // matches an idle-high tck, no false edge after reset
      tmsSyncQ <= 2'h3;
      tdiSyncQ <= 2'h3;
      aSync1Q  <= {PORT_W{1'b0}};
      aSync2Q  <= {PORT_W{1'b0}};
      bSync1Q  <= {PORT_W{1'b0}};
      bSync2Q  <= {PORT_W{1'b0}};
    end else begin
      tckSyncQ <= {tckSyncQ[1:0], tck};
      tmsSyncQ <= {tmsSyncQ[0], tms};
      tdiSyncQ <= {tdiSyncQ[0], tdi};
      aSync1Q  <= aPinIn;
      aSync2Q  <= aSync1Q;
      bSync1Q  <= bPinIn;
      bSync2Q  <= bSync1Q;
    end
  end

  // ----------------------------------------------------------------
  // state and registers
  // ----------------------------------------------------------------
  reg [3:0]              stateQ;
  reg [`BRE_IR_W-1:0]    irShiftQ, irQ;
  reg [`BRE_CTRL_W-1:0]  ctrlQ;
  reg                    bypassQ;
  reg [`BRE_CHAIN_W-1:0] chainQ, shadowQ;

  wire tmsS = tmsSyncQ[1];
  wire tdiS = tdiSyncQ[1];

  // instruction classes
  wire selCtrl  = (irQ == `BRE_OP_CTRL_NORMAL) || (irQ == `BRE_OP_CTRL_TEST);
  wire selChain = (irQ == `BRE_OP_READ_NORMAL) || (irQ == `BRE_OP_READ_TEST);
  wire isRun    = (irQ == `BRE_OP_RUN);

  // R8 enable legality from the enable cells' latches
  wire en1ab = shadowQ[`BRE_CELL_AB_EN1];
  wire en2ab = shadowQ[`BRE_CELL_AB_EN2];
  wire en1ba = shadowQ[`BRE_CELL_BA_EN1];
  wire en2ba = shadowQ[`BRE_CELL_BA_EN2];
  // both bytes must face one way, else a port would be half input, half output
  wire dirOk = (en1ab != en1ba) && (en2ab != en2ba) && (en1ab == en2ab);
  // R22 active-low enable: zero means a-to-b drives b
  wire aToB  = ~en1ab;
  // R21 test mode only with a legal direction
  wire runOk = isRun && dirOk;

  // R18 input and output cells swap with the direction
  wire [17:0] inCells  = aToB ? chainQ[`BRE_A_LSB +: 18] : chainQ[`BRE_B_LSB +: 18];
  wire [17:0] outCells = aToB ? chainQ[`BRE_B_LSB +: 18] : chainQ[`BRE_A_LSB +: 18];
  wire [17:0] inPins   = aToB ? aSync2Q[17:0] : bSync2Q[17:0];

  // R3 decode of the operation code
  wire [1:0] codeLow   = ctrlQ[1:0];
  wire       codeCount = ctrlQ[2];

  // algorithm result for the input and output halves
  reg [17:0] inNext, outNext;
  reg [35:0] wide;

  always @* begin
    wide    = 36'h000000000;
    inNext  = inCells;
    outNext = outCells;
    case (codeLow)
      // R4 sample and toggle
      `BRE_CODE_TOGGLE: begin
        // R9 inputs captured
        inNext  = inPins;
        // R10 outputs inverted
        outNext = ~outCells;
      end
      // R5 R11 36-bit pattern
      `BRE_CODE_PATTERN36: begin
        wide    = step36({outCells, inCells});
        outNext = wide[35:18];
        inNext  = wide[17:0];
      end
      // R5 R14 36-bit signature
      `BRE_CODE_SIGN36: begin
        wide    = step36({outCells, inCells}) ^ {18'h00000, inPins};
        outNext = wide[35:18];
        inNext  = wide[17:0];
      end
      // R6 combined modes
      default: begin
        // R16 R17 18-bit signature
        inNext = step18(inCells) ^ inPins;
        if (codeCount) begin
          // R20 wrapping count
          outNext = outCells + 18'h00001;
        end else begin
          // R16 18-bit pattern
          outNext = step18(outCells);
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // rising tck: tap, capture, shift and run
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (!reset_n) begin
      stateQ   <= ST_RESET;
      irShiftQ <= `BRE_IR_RESET;
      ctrlQ    <= `BRE_CTRL_RESET;
      bypassQ  <= 1'b0;
      chainQ   <= `BRE_CHAIN_RESET;
    end else if (tckRise) begin
      stateQ <= tapNext(stateQ, tmsS);
      case (stateQ)
        ST_CAP_IR: irShiftQ <= `BRE_IR_CAPTURE;
        ST_SH_IR:  irShiftQ <= {tdiS, irShiftQ[`BRE_IR_W-1:1]};
        // R1 control and chain hold during capture
        ST_CAP_DR: bypassQ <= 1'b0;
        ST_SH_DR: begin
          if (selCtrl) begin
            // R1 control register in the scan path
            ctrlQ <= {tdiS, ctrlQ[`BRE_CTRL_W-1:1]};
          end else if (selChain) begin
            // R12 seed path into the chain
            chainQ <= {tdiS, chainQ[`BRE_CHAIN_W-1:1]};
          end else begin
            bypassQ <= tdiS;
          end
        end
        ST_IDLE: begin
          // R3 run only in idle under the run instruction
          // R7 cells 47..36 are never touched here
          if (runOk) begin
            chainQ[`BRE_A_LSB +: 18] <= aToB ? inNext : outNext;
            chainQ[`BRE_B_LSB +: 18] <= aToB ? outNext : inNext;
          end
        end
        default: irShiftQ <= irShiftQ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // falling tck: updates, shadow latches, tdo
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (!reset_n) begin
      irQ     <= `BRE_IR_RESET;
      shadowQ <= `BRE_CHAIN_RESET;
      tdo     <= 1'b0;
      tdoOe   <= 1'b0;
    end else if (tckFall) begin
      tdoOe <= (stateQ == ST_SH_IR) || (stateQ == ST_SH_DR);
      if (stateQ == ST_SH_IR) begin
        tdo <= irShiftQ[0];
      end else if (selCtrl) begin
        tdo <= ctrlQ[0];
      end else if (selChain) begin
        tdo <= chainQ[0];
      end else begin
        tdo <= bypassQ;
      end
      if (stateQ == ST_RESET) begin
        irQ <= `BRE_IR_RESET;
      end else if (stateQ == ST_UPD_IR) begin
        irQ <= irShiftQ;
      end
      if (stateQ == ST_UPD_DR && selChain) begin
        shadowQ <= chainQ;
      end else if (stateQ == ST_IDLE && runOk && codeLow != `BRE_CODE_SIGN36) begin
        // R10 R11 R16 R17 outputs latched on the fall
        // R15 held while 36-bit signature runs
        if (aToB) begin
          shadowQ[`BRE_B_LSB +: 18] <= chainQ[`BRE_B_LSB +: 18];
        end else begin
          shadowQ[`BRE_A_LSB +: 18] <= chainQ[`BRE_A_LSB +: 18];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  // outside test mode the normal datapath owns the pins, so release them
  always @(posedge clk) begin
    if (!reset_n) begin
      aPinOut  <= {PORT_W{1'b0}};
      aPinOe   <= {PORT_W{1'b0}};
      bPinOut  <= {PORT_W{1'b0}};
      bPinOe   <= {PORT_W{1'b0}};
      testMode <= 1'b0;
    end else begin
      testMode <= runOk;
      aPinOut  <= shadowQ[`BRE_A_LSB +: PORT_W];
      bPinOut  <= shadowQ[`BRE_B_LSB +: PORT_W];
      // R7 R22 enable cells set each byte's drive
      aPinOe   <= runOk ? {{(PORT_W-HALF){~en2ba}}, {HALF{~en1ba}}} : {PORT_W{1'b0}};
      bPinOe   <= runOk ? {{(PORT_W-HALF){~en2ab}}, {HALF{~en1ab}}} : {PORT_W{1'b0}};
    end
  end

endmodule // bre_boundary_run_engine

`default_nettype wire

// [bre_run_properties.sv]
// port assertions for the boundary-run engine
`timescale 1ns/1ps
`default_nettype none
module bre_run_props #(
  parameter PORT_W = 18
) (
  input wire logic              clk,
  input wire logic              reset_n,
  input wire logic              tck,
  input wire logic              tms,
  input wire logic              tdi,
  input wire logic              tdo,
  input wire logic              tdoOe,
  input wire logic [PORT_W-1:0] aPinIn,
  input wire logic [PORT_W-1:0] aPinOut,
  input wire logic [PORT_W-1:0] aPinOe,
  input wire logic [PORT_W-1:0] bPinIn,
  input wire logic [PORT_W-1:0] bPinOut,
  input wire logic [PORT_W-1:0] bPinOe,
  input wire logic              testMode
);
  logic       tckQ;
  logic [2:0] sinceFall;
  // clocks since the test clock pin fell; saturates so old falls never match
  always_ff @(posedge clk) begin
    tckQ <= tck;
    if (!reset_n) sinceFall <= 3'h7;
    else if (tckQ && !tck) sinceFall <= 3'h0;
    else if (sinceFall != 3'h7) sinceFall <= sinceFall + 3'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  AST_OE_IDLE: assert property (!testMode |-> (aPinOe | bPinOe) == '0)
    else $error("pin drive outside test mode");
  AST_OE_SPLIT: assert property (testMode |-> (aPinOe ^ bPinOe) == '1)
    else $error("ports not split into inputs and outputs");
  AST_OE_WHOLE: assert property (testMode |-> aPinOe == '0 || aPinOe == '1)
    else $error("bytes driven in different directions");
  AST_OE_HOLD: assert property (testMode && $past(testMode) |-> $stable(aPinOe | bPinOe))
    else $error("drive state moved during a test run");
  AST_TDO_FALL: assert property ($changed(tdo) |-> sinceFall inside {[1:5]})
    else $error("serial output moved away from a falling edge");
  AST_PIN_FALL: assert property ($changed(aPinOut ^ bPinOut) |-> sinceFall inside {[1:6]})
    else $error("pin outputs moved away from a falling edge");
  AST_MODE_FALL: assert property ($changed(testMode) |-> sinceFall inside {[1:6]})
    else $error("test mode moved away from a falling edge");
  AST_OEN_FALL: assert property ($changed(tdoOe) |-> sinceFall inside {[1:5]})
    else $error("serial enable moved away from a falling edge");
  COV_MODE: cover property ($rose(testMode));
  COV_ATOB: cover property (testMode && bPinOe == '1);
  COV_BTOA: cover property (testMode && aPinOe == '1);
endmodule // bre_run_props
bind bre_boundary_run_engine bre_run_props #(.PORT_W(PORT_W)) uProps (
  .clk(clk), .reset_n(reset_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
  .tdoOe(tdoOe), .aPinIn(aPinIn), .aPinOut(aPinOut), .aPinOe(aPinOe), .bPinIn(bPinIn),
  .bPinOut(bPinOut), .bPinOe(bPinOe), .testMode(testMode));
`default_nettype wire

// [bre_tap_host.sv]
// test controller model driving the four-wire port
`timescale 1ns/1ps
`default_nettype none
module bre_tap_host (
  input  wire logic clk,
  output var  logic tck,
  output var  logic tms,
  output var  logic tdi,
  input  wire logic tdo
);
  // test clock stands high between periods
  initial begin
    tck = 1'b1;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // one 80 ns period: fall and drive, then sample and rise
  task automatic step(input logic m, input logic d, output logic q);
    @(posedge clk);
    #1;
    tck = 1'b0;
    tms = m;
    tdi = d;
    repeat (4) @(posedge clk);
    #1;
    q = tdo;
    tck = 1'b1;
    repeat (3) @(posedge clk);
  endtask
  // idle to shift, n bits lsb first, back to idle
  task automatic scan(input logic isIr, input logic [47:0] v, input int n,
                      output logic [47:0] q);
    logic b;
    q = '0;
    step(1'b1, 1'b0, b);
    if (isIr) step(1'b1, 1'b0, b);
    step(1'b0, 1'b0, b);
    step(1'b0, 1'b0, b);
    for (int i = 0; i < n; i++) step(i == n - 1, v[i], q[i]);
    step(1'b1, 1'b0, b);
    step(1'b0, 1'b0, b);
  endtask
endmodule // bre_tap_host
`default_nettype wire

// [tb_boundary_run_test_engine.sv]
// self-checking bench for the boundary-run engine
`timescale 1ns/1ps
`default_nettype none
`include "bre_consts.vh"
module tb_boundary_run_test_engine;
  localparam logic [17:0] PA = 18'h2D3C1;
  localparam logic [17:0] PB = 18'h1B4E7;
  logic        clk, reset_n, tck, tms, tdi, tdo, tdoOe, testMode, b;
  logic [17:0] aPinOut, aPinOe, bPinOut, bPinOe, aPinIn, bPinIn;
  logic [2:0]  prevCode;
  int          n_mismatch = 0;
  int          comparisons = 0;
  // pins resolve to the driver when enabled, else the board value
  assign aPinIn = (aPinOe & aPinOut) | (~aPinOe & PA);
  assign bPinIn = (bPinOe & bPinOut) | (~bPinOe & PB);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  bre_boundary_run_engine #(.PORT_W(18)) uut (
    .clk(clk), .reset_n(reset_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdoOe(tdoOe), .aPinIn(aPinIn), .aPinOut(aPinOut), .aPinOe(aPinOe), .bPinIn(bPinIn),
    .bPinOut(bPinOut), .bPinOe(bPinOe), .testMode(testMode));
  bre_tap_host host (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("compares %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  function automatic logic [35:0] sw(input logic [35:0] x);
    return {x[17:0], x[35:18]};
  endfunction
  function automatic logic [35:0] nxt(input logic [2:0] c, input logic [35:0] r,
                                      input logic [17:0] p);
    logic [17:0] o;
    o = r[35:18];
    case (c[1:0])
      2'h0: return {~o, p};
      2'h1: return {r[34:0], r[35] ^ r[24]};
      2'h2: return {r[34:0], r[35] ^ r[24]} ^ {18'h0, p};
      default: return {c[2] ? o + 18'h1 : {o[16:0], o[17] ^ o[10]},
                       {r[16:0], r[17] ^ r[10]} ^ p};
    endcase
  endfunction
  // load code and seed, idle six periods, check pins and chain
  task automatic run(input logic [2:0] c, input logic [3:0] oe, input logic [35:0] s,
                     input logic ok);
    logic [47:0] q;
    logic [35:0] r;
    logic [17:0] pinExp;
    logic        d;
    logic [35:0] oeExp;
    d = oe[3];
    oeExp = d ? {18'h3FFFF, 18'h00000} : {18'h00000, 18'h3FFFF};
    r = d ? sw(s) : s;
    pinExp = r[35:18];
    host.scan(1'b1, {40'h0, `BRE_OP_CTRL_NORMAL}, 8, q);
    chk(q[7:0], `BRE_IR_CAPTURE);
    host.scan(1'b0, {45'h0, c}, 3, q);
    chk(q[2:0], prevCode);
    prevCode = c;
    host.scan(1'b1, {40'h0, `BRE_OP_READ_NORMAL}, 8, q);
    host.scan(1'b0, {oe, 8'h00, s}, 48, q);
    host.scan(1'b1, {40'h0, `BRE_OP_RUN}, 8, q);
    for (int k = 0; k < 6; k++) host.step(1'b0, 1'b0, b);
    chk(testMode, ok);
    chk({aPinOe, bPinOe}, ok ? oeExp : 36'h0);
    // seven rises in idle in all; the pins show the fifth step, or the seed under 36-bit signature
    for (int k = 1; k < 8; k++) begin
      if (ok) r = nxt(c, r, d ? PB : PA);
      if (k == 5 && c[1:0] != 2'h2) pinExp = r[35:18];
    end
    chk(d ? aPinOut : bPinOut, pinExp);
    host.scan(1'b1, {40'h0, `BRE_OP_READ_NORMAL}, 8, q);
    host.scan(1'b0, 48'h0, 48, q);
    chk(q, {oe, 8'h00, d ? sw(r) : r});
    $display("test code %b enables %b done", c, oe);
  endtask
  // watchdog cuts a hang short
  initial begin
    #400000;
    n_mismatch++;
    results();
  end
  initial begin
    reset_n = 1'b0;
    prevCode = `BRE_CTRL_RESET;
    repeat (4) @(posedge clk);
    #1 reset_n = 1'b1;
    repeat (4) @(posedge clk);
    host.step(1'b0, 1'b0, b);
    for (int c = 0; c < 8; c++) run(c[2:0], 4'h3, 36'h9A5C31E7B, 1'b1);
    run(3'h3, 4'hC, 36'h5E1D07C39, 1'b1);
    run(3'h7, 4'hC, 36'h5E1D07C39, 1'b1);
    run(3'h0, 4'hC, 36'h3FFFF0000, 1'b1);
    run(3'h1, 4'h3, 36'h0, 1'b1);
    run(3'h3, 4'h3, 36'h0, 1'b1);
    run(3'h2, 4'h0, 36'h9A5C31E7B, 1'b0);
    run(3'h1, 4'h5, 36'h9A5C31E7B, 1'b0);
    results();
  end
endmodule // tb_boundary_run_test_engine
`default_nettype wire
